/* rtl/tqc_defines.svh */
// register offsets, field positions and reset values of the timer
`ifndef TQC_DEFINES_SVH
`define TQC_DEFINES_SVH
`define TQC_OFS_CTL0   8'h00
`define TQC_OFS_CTL1   8'h04
`define TQC_OFS_OUTCTL 8'h08
`define TQC_OFS_EDGEA  8'h0c
`define TQC_OFS_EDGEB  8'h10
`define TQC_OFS_CCR0   8'h14
`define TQC_OFS_CNT    8'h24
`define TQC_OFS_STAT   8'h28
`define TQC_OFS_MASK   8'h2c
`define TQC_CTL0_CE    7
`define TQC_CTL1_SYE   7
`define TQC_CTL1_EST   6
`define TQC_CTL1_EEE   5
`define TQC_RST_BYTE   8'h00
`define TQC_RST_WORD   16'h0000
`define TQC_CNT_IDLE   16'hffff
`define TQC_CNT_READ0  16'h0000
`define TQC_RESP_OKAY  2'b00
`define TQC_RESP_ERR   2'b10
`endif

/* rtl/tqc_pkg.sv */
// types shared by the timer modules
package tqc_pkg;
   typedef enum logic [2:0] {
      MD_INTERVAL, MD_EXT_EVENT, MD_EXT_TRIG, MD_ONE_SHOT,
      MD_PWM, MD_FREE_RUN, MD_PULSE_WIDTH, MD_TRI_PWM
   } tqc_mode_e;
   typedef logic [15:0] tqc_word_t;
endpackage

/* rtl/tqc_link_if.sv */
// signals between the timer core, its prescaler and its edge detector
`timescale 1ns/100ps
`default_nettype none
interface tqc_link_if;
   logic       clkEn;
   logic [3:0] pin;
   logic [3:0] rise;
   logic [3:0] fall;
   logic [2:0] cks;
   logic       run;
   logic       tick;
   modport core (output clkEn, pin, cks, run, input rise, fall, tick);
   modport det  (input clkEn, pin, output rise, fall);
   modport pre  (input clkEn, cks, run, output tick);
endinterface
`default_nettype wire

/* rtl/tqc_edge_det.sv */
// synchroniser and edge detector for the four timer inputs
`timescale 1ns/100ps
`default_nettype none
module tqc_edge_det
   import tqc_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_b,
   tqc_link_if.det   lnk
);
   logic [3:0] syncA;
   logic [3:0] syncB;
   logic [3:0] prevB;

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         syncA <= 4'h0;
         syncB <= 4'h0;
         prevB <= 4'h0;
      end
      else if (lnk.clkEn)
      begin
         syncA <= lnk.pin;
         syncB <= syncA;
         prevB <= syncB;
      end
   end

   // one pulse per edge, held only one enabled cycle
   assign lnk.rise = syncB & ~prevB;
   assign lnk.fall = ~syncB & prevB;
endmodule // tqc_edge_det
`default_nettype wire

/* rtl/tqc_prescaler.sv */
// internal count clock divider, one of eight rates
`timescale 1ns/100ps
`default_nettype none
module tqc_prescaler
   import tqc_pkg::*;
#(
   parameter int DIV_W = 7
)
(
   input  wire logic clk,
   input  wire logic rst_b,
   tqc_link_if.pre   lnk
);
   logic [DIV_W-1:0] div;
   logic [DIV_W-1:0] mask;

   assign mask = DIV_W'((1 << lnk.cks) - 1);

   always_ff @(posedge clk)
   begin
      if (!rst_b)
         div <= '0;
      else if (lnk.clkEn)
      begin
         // restart so the first tick after enable is a full period
         if (!lnk.run)
            div <= '0;
         else
            div <= div + DIV_W'(1);
      end
   end

   assign lnk.tick = lnk.run && ((div & mask) == mask);
endmodule // tqc_prescaler
`default_nettype wire

/* rtl/tqc_top.sv */
// 16-bit timer/event counter with four capture/compare channels
// Notes on behaviour
// - One 16-bit up/down counter advances on a divided internal clock or on external events.
// - With counting disabled the counter holds all ones and reads back as zero.
// - Reset clears the count enable, leaving the counter at all ones.
// - Software reads the running count directly from the counter register.
// - A compare value written to a channel register is moved into its compare buffer.
// - Counter equal to a channel's compare buffer raises that channel's match request, except on a channel with a capture edge set in a capture mode.
// - Compare buffers have no address and load only from their channel registers.
// - Reset clears every channel register and compare buffer to zero.
// - Each input's valid edge is none, rising, falling or both, set by two edge registers.
// - An output controller drives the four timer outputs under the output control register.
// - Input 0 acts as capture trigger, event count input or trigger input by mode.
// - The count clock is one of nine selectable sources.
// - There are four capture inputs, one event count input and one trigger input.
// - Eight operating modes plus slaved operation to a master timer are supported.
// - The selector picks one of eight divided clocks or the external event input.
//
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
`include "tqc_defines.svh"
`default_nettype none
module tqc_top
   import tqc_pkg::*;
#(
   parameter int CNT_W  = 16,
   parameter int ADDR_W = 8
)
(
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire logic              clkEn,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic [3:0]        timerInput,
   input  wire logic              masterSync,
   output logic [3:0]             timerOutput,
   output logic [3:0]             compareMatchIrq,
   output logic                   irq
);
   localparam logic [CNT_W-1:0] IDLE = CNT_W'(`TQC_CNT_IDLE);
   localparam logic [CNT_W-1:0] ONE  = CNT_W'(1);

   tqc_link_if lnk ();

   logic [7:0]       ctl0;
   logic [7:0]       ctl1;
   logic [7:0]       outputControlReg;
   logic [7:0]       edgeSelectRegA;
   logic [7:0]       edgeSelectRegB;
   logic [CNT_W-1:0] ccr    [4];
   logic [CNT_W-1:0] cmpBuf [4];
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic             running;
   logic             next_running;
   logic             countDown;
   logic             next_countDown;
   logic             cntStep;
   logic [3:0]       statusReg;
   logic [3:0]       maskReg;
   logic [3:0]       outState;
   logic             awHeld;
   logic             wHeld;
   logic [ADDR_W-1:0] awAddr;
   logic [31:0]      wData;
   logic [3:0]       wStrb;
   logic             doWrite;
   logic [31:0]      rdMux;
   tqc_mode_e        mode;
   logic             countEnable;
   logic [3:0]       capEdge;
   logic [3:0]       capEvt;
   logic [3:0]       matchEvt;
   logic             evtEdge;
   logic             trigEdge;
   logic             tick;
   logic             needsTrig;
   logic             capMode;
   logic             trigger;
   logic             run;
   logic             atTop;
   logic             periodStart;
   logic             loadBuf;

   function automatic logic edgeHit(input logic [1:0] sel, input logic r, input logic f);
      return (sel[0] & r) | (sel[1] & f);
   endfunction

   function automatic logic isMapped(input logic [ADDR_W-1:0] a);
      return (a[1:0] == 2'b00) && (a <= ADDR_W'(`TQC_OFS_MASK));
   endfunction

   function automatic logic [15:0] mergeWord(input logic [15:0] old,
                                             input logic [31:0] d,
                                             input logic [3:0]  s);
      return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   assign countEnable = ctl0[`TQC_CTL0_CE];
   assign mode        = tqc_mode_e'(ctl1[2:0]);

   // sub blocks
   assign lnk.clkEn = clkEn;
   assign lnk.pin   = timerInput;
   assign lnk.cks   = ctl0[2:0];
   assign lnk.run   = countEnable;

   tqc_edge_det u_edge (
      .clk   (clk),
      .rst_b (rst_b),
      .lnk   (lnk)
   );

   tqc_prescaler #(.DIV_W(7)) u_pre (
      .clk   (clk),
      .rst_b (rst_b),
      .lnk   (lnk)
   );

   // AXI4-Lite write channel, address and data accepted in either order
   assign s_axi_awready = !awHeld && !s_axi_bvalid;
   assign s_axi_wready  = !wHeld && !s_axi_bvalid;
   assign doWrite       = awHeld && wHeld;

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         awHeld       <= 1'b0;
         wHeld        <= 1'b0;
         awAddr       <= '0;
         wData        <= 32'h0;
         wStrb        <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `TQC_RESP_OKAY;
      end
      else if (clkEn)
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
         end
         else if (doWrite)
            awHeld <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end
         else if (doWrite)
            wHeld <= 1'b0;
         if (doWrite)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= isMapped(awAddr) ? `TQC_RESP_OKAY : `TQC_RESP_ERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // control registers
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         ctl0             <= `TQC_RST_BYTE;
         ctl1             <= `TQC_RST_BYTE;
         outputControlReg <= `TQC_RST_BYTE;
         edgeSelectRegA   <= `TQC_RST_BYTE;
         edgeSelectRegB   <= `TQC_RST_BYTE;
         maskReg          <= 4'h0;
      end
      else if (clkEn && doWrite && wStrb[0])
      begin
         unique case (awAddr)
            ADDR_W'(`TQC_OFS_CTL0):   ctl0 <= wData[7:0] & 8'h87;
            // trigger bit is a strobe and is never stored
            ADDR_W'(`TQC_OFS_CTL1):   ctl1 <= wData[7:0] & 8'ha7;
            ADDR_W'(`TQC_OFS_OUTCTL): outputControlReg <= wData[7:0];
            ADDR_W'(`TQC_OFS_EDGEA):  edgeSelectRegA <= wData[7:0];
            ADDR_W'(`TQC_OFS_EDGEB):  edgeSelectRegB <= wData[7:0];
            ADDR_W'(`TQC_OFS_MASK):   maskReg <= wData[3:0];
            default:                  ;
         endcase
      end
   end

   // edge roles and count source
   always_comb
   begin
      for (int m = 0; m < 4; m++)
         capEdge[m] = edgeHit(edgeSelectRegA[2*m +: 2], lnk.rise[m], lnk.fall[m]);
   end

   assign evtEdge   = edgeHit(edgeSelectRegB[1:0], lnk.rise[0], lnk.fall[0]);
   assign trigEdge  = edgeHit(edgeSelectRegB[3:2], lnk.rise[0], lnk.fall[0]);
   assign tick      = (ctl1[`TQC_CTL1_EEE] || mode == MD_EXT_EVENT) ? evtEdge : lnk.tick;
   assign needsTrig = (mode == MD_EXT_TRIG) || (mode == MD_ONE_SHOT);
   assign capMode   = (mode == MD_FREE_RUN) || (mode == MD_PULSE_WIDTH);
   assign trigger   = needsTrig && ((doWrite && wStrb[0] && awAddr == ADDR_W'(`TQC_OFS_CTL1)
                      && wData[`TQC_CTL1_EST]) || trigEdge);
   assign run       = needsTrig ? running : 1'b1;
   assign atTop     = (cnt == cmpBuf[0]);
   assign capEvt    = capMode ? capEdge : 4'h0;

   // next count, per mode
   always_comb
   begin
      next_cnt       = cnt;
      next_running   = running;
      next_countDown = countDown;
      cntStep        = 1'b0;
      if (!countEnable)
      begin
         next_cnt       = IDLE;
         next_running   = 1'b0;
         next_countDown = 1'b0;
      end
      else if (trigger)
      begin
         // a retrigger restarts the period from the idle value
         next_cnt     = IDLE;
         next_running = 1'b1;
      end
      else if (mode == MD_PULSE_WIDTH && capEdge[0])
         next_cnt = '0;
      else if (tick && run)
      begin
         cntStep = 1'b1;
         unique case (mode)
            MD_FREE_RUN, MD_PULSE_WIDTH:
               next_cnt = cnt + ONE;
            MD_TRI_PWM:
               if (countDown)
               begin
                  next_cnt = cnt - ONE;
                  if (cnt == ONE)
                     next_countDown = 1'b0;
               end
               else if (atTop)
               begin
                  next_cnt       = cnt - ONE;
                  next_countDown = 1'b1;
               end
               else
                  next_cnt = cnt + ONE;
            MD_ONE_SHOT:
               if (atTop)
               begin
                  next_cnt     = IDLE;
                  next_running = 1'b0;
                  cntStep      = 1'b0;
               end
               else
                  next_cnt = cnt + ONE;
            MD_INTERVAL, MD_EXT_EVENT, MD_EXT_TRIG, MD_PWM:
               next_cnt = atTop ? '0 : cnt + ONE;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         cnt       <= IDLE;
         running   <= 1'b0;
         countDown <= 1'b0;
      end
      else if (clkEn)
      begin
         cnt       <= next_cnt;
         running   <= next_running;
         countDown <= next_countDown;
      end
   end

   // compare detect on the value the counter is stepping into
   always_comb
   begin
      for (int m = 0; m < 4; m++)
         matchEvt[m] = cntStep && !(capMode && capEdge[m] && m > 0)
                       && (next_cnt == cmpBuf[m]) && !(capMode && edgeSelectRegA[2*m +: 2] != 2'b00);
   end

   assign periodStart = cntStep && (next_cnt == '0);

   // buffer transfer: slaved, at period start, or straight through
   always_comb
   begin
      if (ctl1[`TQC_CTL1_SYE])
         loadBuf = masterSync;
      else if (countEnable && (mode == MD_INTERVAL || mode == MD_EXT_EVENT
               || mode == MD_EXT_TRIG || mode == MD_PWM || mode == MD_TRI_PWM))
         loadBuf = periodStart;
      else
         loadBuf = 1'b1;
   end

   // channel registers and their hidden buffers
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         for (int m = 0; m < 4; m++)
         begin
            ccr[m]    <= CNT_W'(`TQC_RST_WORD);
            cmpBuf[m] <= CNT_W'(`TQC_RST_WORD);
         end
      end
      else if (clkEn)
      begin
         for (int m = 0; m < 4; m++)
         begin
            if (capEvt[m])
               ccr[m] <= cnt;
            else if (doWrite && awAddr == ADDR_W'(`TQC_OFS_CCR0 + 4 * m))
               ccr[m] <= mergeWord(ccr[m], wData, wStrb);
            if (loadBuf)
               cmpBuf[m] <= ccr[m];
         end
      end
   end

   // sticky events, set wins over write-one-to-clear
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         statusReg       <= 4'h0;
         compareMatchIrq <= 4'h0;
         irq             <= 1'b0;
      end
      else if (clkEn)
      begin
         compareMatchIrq <= matchEvt | capEvt;
         statusReg <= (statusReg & ~((doWrite && wStrb[0]
                      && awAddr == ADDR_W'(`TQC_OFS_STAT)) ? wData[3:0] : 4'h0))
                      | matchEvt | capEvt;
         irq <= |(statusReg & maskReg);
      end
   end

   // output controller: enable at bit 2m, idle level at bit 2m+1
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         outState    <= 4'h0;
         timerOutput <= 4'h0;
      end
      else if (clkEn)
      begin
         if (!countEnable)
            outState <= 4'h0;
         else
         begin
            if (matchEvt[0])
               outState[0] <= ~outState[0];
            for (int m = 1; m < 4; m++)
            begin
               if (mode == MD_PWM || mode == MD_ONE_SHOT || mode == MD_EXT_TRIG)
               begin
                  if (matchEvt[m])
                     outState[m] <= 1'b0;
                  else if (periodStart)
                     outState[m] <= 1'b1;
               end
               else if (matchEvt[m])
                  outState[m] <= ~outState[m];
            end
         end
         for (int m = 0; m < 4; m++)
            timerOutput[m] <= outputControlReg[2*m+1]
                              ^ (outputControlReg[2*m] & outState[m]);
      end
   end

   // read channel
   always_comb
   begin
      rdMux = 32'h0;
      unique case (s_axi_araddr)
         ADDR_W'(`TQC_OFS_CTL0):     rdMux[7:0] = ctl0;
         ADDR_W'(`TQC_OFS_CTL1):     rdMux[7:0] = ctl1;
         ADDR_W'(`TQC_OFS_OUTCTL):   rdMux[7:0] = outputControlReg;
         ADDR_W'(`TQC_OFS_EDGEA):    rdMux[7:0] = edgeSelectRegA;
         ADDR_W'(`TQC_OFS_EDGEB):    rdMux[7:0] = edgeSelectRegB;
         ADDR_W'(`TQC_OFS_CCR0):     rdMux[15:0] = ccr[0];
         ADDR_W'(`TQC_OFS_CCR0 + 4): rdMux[15:0] = ccr[1];
         ADDR_W'(`TQC_OFS_CCR0 + 8): rdMux[15:0] = ccr[2];
         ADDR_W'(`TQC_OFS_CCR0 + 12): rdMux[15:0] = ccr[3];
         ADDR_W'(`TQC_OFS_CNT):      rdMux[15:0] = countEnable ? cnt : `TQC_CNT_READ0;
         ADDR_W'(`TQC_OFS_STAT):     rdMux[3:0] = statusReg;
         ADDR_W'(`TQC_OFS_MASK):     rdMux[3:0] = maskReg;
         default:                    rdMux = 32'h0;
      endcase
   end

   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= `TQC_RESP_OKAY;
      end
      else if (clkEn)
      begin
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdMux;
            s_axi_rresp  <= isMapped(s_axi_araddr) ? `TQC_RESP_OKAY : `TQC_RESP_ERR;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end
endmodule // tqc_top
`default_nettype wire

/* test/tqc_top_sva.sv */
// concurrent checks on the timer's bus and request ports
`timescale 1ns/100ps
`default_nettype none
module tqc_top_sva
   import tqc_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [3:0]  timerOutput,
   input wire logic [3:0]  compareMatchIrq,
   input wire logic        irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   AST_RESET_QUIET: assert property ($rose(rst_b) |->
      compareMatchIrq == 4'h0 && !irq && timerOutput == 4'h0 && !s_axi_bvalid && !s_axi_rvalid)
      else $error("outputs not quiet after reset");
   AST_WRITE_ANSWER: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response late");
   AST_BVALID_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   AST_BUSY_REFUSES: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   AST_BRESP_CODE: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'b00, 2'b10})
      else $error("bad write response code");
   AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   AST_RDATA_STANDS: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data changed before taken");
   AST_READ_REFUSES: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data pending");
   AST_RDATA_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
      else $error("upper read bits not zero");
endmodule // tqc_top_sva
bind tqc_top tqc_top_sva tqc_top_sva_i (.clk(clk), .rst_b(rst_b),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .timerOutput(timerOutput),
   .compareMatchIrq(compareMatchIrq), .irq(irq));
`default_nettype wire

/* test/tqc_pin_model.sv */
// model of the external timer input pins
`timescale 1ns/100ps
`default_nettype none
module tqc_pin_model
(
   input  wire logic  clk,
   output logic [3:0] timerInput
);
   initial timerInput = 4'h0;
   // levels held four cycles so the synchroniser sees each edge
   task automatic pulse(input int ch, input int n);
      repeat (n)
      begin
         @(posedge clk);
         timerInput[ch] <= 1'b1;
         repeat (4) @(posedge clk);
         timerInput[ch] <= 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask
endmodule // tqc_pin_model
`default_nettype wire

/* test/tb.sv */
// self-checking bench for the four-channel timer
`timescale 1ns/100ps
`include "tqc_defines.svh"
`default_nettype none
module tb import tqc_pkg::*; ;
   logic        clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rdTmp;
   logic [1:0]  bresp, rresp;
   logic        awready, wready, bvalid, arready, rvalid, irq;
   logic [3:0]  timerInput, timerOutput, compareMatchIrq;
   tqc_word_t   cntA;
   int          mismatches = 0;
   int          compares = 0;
   int          cycles = 0;
   initial
   begin
      {rst_b, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      {awaddr, araddr, wdata} = 48'h0;
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   tqc_top tqc_top_i (.clk(clk), .rst_b(rst_b), .clkEn(1'b1), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .timerInput(timerInput), .masterSync(1'b0),
      .timerOutput(timerOutput), .compareMatchIrq(compareMatchIrq), .irq(irq));
   tqc_pin_model pins_i (.clk(clk), .timerInput(timerInput));
   task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string m);
      compares++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
      end
   endtask
   task automatic check_resp(input logic [1:0] got, input logic [1:0] exp, input string m);
      compares++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: %s response %b want %b", $time, m, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic done;
      done = 1'b0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done)
      begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid)
         begin
            bready <= 1'b0;
            check_resp(bresp, er, "write");
            done = 1'b1;
         end
      end
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
      logic done;
      done = 1'b0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done)
      begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid)
         begin
            rready <= 1'b0;
            d = rdata;
            check_resp(rresp, er, "read");
            done = 1'b1;
         end
      end
   endtask
   task automatic test_reset;
      for (int a = 0; a <= 'h2c; a += 4)
      begin
         rd(8'(a), rdTmp, `TQC_RESP_OKAY);
         check_val(rdTmp, 32'h0, "reset value");
      end
      rd(8'h30, rdTmp, `TQC_RESP_ERR);
      check_val({irq, timerOutput}, 32'h0, "outputs after reset");
      $display("test reset done");
   endtask
   task automatic test_channels;
      logic [15:0] vals [4] = '{16'h1000, 16'h0020, 16'h2000, 16'h3000};
      for (int i = 0; i < 4; i++)
      begin
         wr(`TQC_OFS_CCR0 + 8'(4 * i), {16'h0, vals[i]}, `TQC_RESP_OKAY);
         rd(`TQC_OFS_CCR0 + 8'(4 * i), rdTmp, `TQC_RESP_OKAY);
         check_val(rdTmp, {16'h0, vals[i]}, "channel value");
      end
      wr(8'h30, 32'h0000ffff, `TQC_RESP_ERR);
      $display("test channels done");
   endtask
   task automatic test_match;
      int seen;
      seen = 0;
      wr(`TQC_OFS_CTL1, 32'h05, `TQC_RESP_OKAY);
      wr(`TQC_OFS_CTL0, 32'h80, `TQC_RESP_OKAY);
      repeat (200)
      begin
         @(posedge clk);
         if (compareMatchIrq[1] === 1'b1) seen++;
      end
      check_val(seen, 1, "channel 1 match pulses");
      check_val(irq, 1'b0, "masked interrupt");
      rd(`TQC_OFS_STAT, rdTmp, `TQC_RESP_OKAY);
      check_val(rdTmp & 32'h2, 32'h2, "match status");
      wr(`TQC_OFS_MASK, 32'h2, `TQC_RESP_OKAY);
      repeat (3) @(posedge clk);
      check_val(irq, 1'b1, "unmasked interrupt");
      wr(`TQC_OFS_STAT, 32'h2, `TQC_RESP_OKAY);
      repeat (3) @(posedge clk);
      check_val(irq, 1'b0, "cleared interrupt");
      rd(`TQC_OFS_CNT, rdTmp, `TQC_RESP_OKAY);
      check_val(rdTmp[15:0] > 16'h0020, 1'b1, "running count");
      wr(`TQC_OFS_CTL0, 32'h00, `TQC_RESP_OKAY);
      rd(`TQC_OFS_CNT, rdTmp, `TQC_RESP_OKAY);
      check_val(rdTmp, 32'h0, "stopped count");
      // 40 cycles between the two samples at a quarter rate: phase free
      wr(`TQC_OFS_CTL0, 32'h82, `TQC_RESP_OKAY);
      rd(`TQC_OFS_CNT, rdTmp, `TQC_RESP_OKAY);
      cntA = rdTmp[15:0];
      repeat (37) @(posedge clk);
      rd(`TQC_OFS_CNT, rdTmp, `TQC_RESP_OKAY);
      check_val(16'(rdTmp[15:0] - cntA), 16'd10, "divided count");
      $display("test match done");
   endtask
   task automatic test_events;
      logic [15:0] exp [4] = '{16'd0, 16'd3, 16'd3, 16'd6};
      for (int m = 0; m < 4; m++)
      begin
         wr(`TQC_OFS_CTL0, 32'h00, `TQC_RESP_OKAY);
         wr(`TQC_OFS_EDGEB, 32'(m), `TQC_RESP_OKAY);
         wr(`TQC_OFS_CTL1, 32'h25, `TQC_RESP_OKAY);
         wr(`TQC_OFS_CTL0, 32'h80, `TQC_RESP_OKAY);
         rd(`TQC_OFS_CNT, rdTmp, `TQC_RESP_OKAY);
         cntA = rdTmp[15:0];
         pins_i.pulse(0, 3);
         repeat (6) @(posedge clk);
         rd(`TQC_OFS_CNT, rdTmp, `TQC_RESP_OKAY);
         check_val(16'(rdTmp[15:0] - cntA), exp[m], "event count");
      end
      $display("test events done");
   endtask
   task automatic test_outputs;
      wr(`TQC_OFS_OUTCTL, 32'haa, `TQC_RESP_OKAY);
      repeat (3) @(posedge clk);
      check_val(timerOutput, 4'hf, "idle high outputs");
      wr(`TQC_OFS_OUTCTL, 32'h00, `TQC_RESP_OKAY);
      repeat (3) @(posedge clk);
      check_val(timerOutput, 4'h0, "idle low outputs");
      $display("test outputs done");
   endtask
   task give_verdict;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // generous ceiling: the whole sequence needs about 600 cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         give_verdict();
      end
   end
   initial
   begin
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      test_reset();
      test_channels();
      test_match();
      test_events();
      test_outputs();
      give_verdict();
   end
endmodule // tb
`default_nettype wire
